// ---- nvsram_store_recall_control.sv ----
// Purpose: Host side sequencer for store and recall of a 64 x 4 nonvolatile SRAM
// Assumes: Command inputs synchronous to clock; power_good from a supply monitor
// Notes:   Store wait parameter may be shortened in simulation
//          Counters load with the phase length and step down to one
//          Commands are looked at only while idle; those seen while busy are dropped
`timescale 1ns/1ps
`default_nettype none

module nvsram_store_recall_control
    import nvsram_host_pkg::*;
#(
    parameter int STORE_WAIT_CYCLES = nvsram_host_pkg::STORE_CYCLE_CYCLES  // Store completion wait
)
(
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // Command port
    input  wire nvsram_host_pkg::command_type  command,
    input  wire logic                          power_good,
    input  wire logic                          write_active,
    output var  logic                          busy,
    output var  logic                          read_ready,
    output var  logic                          refused,
    output var  logic                          done,
    // Device pins
    output var  nvsram_host_pkg::nv_pins_type  nv_pins
);
    import nvsram_host_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State and counters

    // IDLE is the only state in which host RAM access is allowed
    typedef enum logic [2:0] {
        IDLE,
        RECALL_PULSE,
        RECALL_WAIT,
        STORE_PULSE,
        STORE_WAIT
    } state_type;

    state_type              state_reg;          // Sequencer state
    state_type              state_next;
    logic [COUNT_WIDTH-1:0] count_reg;          // Phase cycle counter
    logic [COUNT_WIDTH-1:0] count_next;
    logic                   mode_reg;           // Latched recall flavour
    logic                   mode_next;
    nv_pins_type            pins_next;          // Next pin levels
    logic                   ready_next;
    logic                   refused_next;
    logic                   done_next;

    ////////////////////////////////////////////////////////////////////////
    // Decodes

    // Strobe low time for the latched recall flavour
    wire logic [COUNT_WIDTH-1:0] recall_low_len =
        (mode_reg == RECALL_LONG) ? COUNT_WIDTH'(RECALL_CYCLE_CYCLES)
                                  : COUNT_WIDTH'(RECALL_PULSE_CYCLES);
    // Quiet time after the strobe rises, before reads
    wire logic [COUNT_WIDTH-1:0] recall_wait_len =
        (mode_reg == RECALL_LONG) ? COUNT_WIDTH'(1)
                                  : COUNT_WIDTH'(RECALL_ACCESS_CYCLES);
    // Store only on good supply and with no write under way
    wire logic store_ok    = power_good && !write_active;
    wire logic count_last  = (count_reg == COUNT_WIDTH'(1));
    wire logic start_rcl   = command.do_recall;
    wire logic start_store = command.do_store && !command.do_recall;

    ////////////////////////////////////////////////////////////////////////
    // Next state logic

    // Phase sequencer; pins and pulses default to idle levels
    // so that every path leaves them driven
    always_comb
    begin
        state_next   = state_reg;
        count_next   = count_reg;
        mode_next    = mode_reg;
        pins_next    = '{store_n: 1'b1, recall_n: 1'b1};
        ready_next   = 1'b0;
        refused_next = 1'b0;
        done_next    = 1'b0;
        unique case (state_reg)
            IDLE:
            begin
                ready_next = 1'b1;                          // Plain RAM access allowed
                if (start_rcl)
                begin
                    // Recall whole array, never while storing
                    state_next = RECALL_PULSE;
                    mode_next  = command.recall_mode;
                    count_next = (command.recall_mode == RECALL_LONG) ?
                                 COUNT_WIDTH'(RECALL_CYCLE_CYCLES) : COUNT_WIDTH'(RECALL_PULSE_CYCLES);
                    pins_next.recall_n = 1'b0;
                    ready_next = 1'b0;
                end
                else if (start_store && store_ok)
                begin
                    state_next = STORE_PULSE;
                    count_next = COUNT_WIDTH'(STORE_PULSE_CYCLES);
                    pins_next.store_n = 1'b0;
                    ready_next = 1'b0;
                end
                else if (start_store)
                begin
                    refused_next = 1'b1;
                end
            end
            RECALL_PULSE:
            begin
                // Strobe held low for the chosen width
                if (count_last)
                begin
                    state_next = RECALL_WAIT;
                    count_next = recall_wait_len;
                end
                else
                begin
                    count_next = count_reg - COUNT_WIDTH'(1);
                    pins_next.recall_n = 1'b0;
                end
            end
            RECALL_WAIT:
            begin
                // Reads barred until access delay passed
                if (count_last)
                begin
                    state_next = IDLE;
                    ready_next = 1'b1;
                    done_next  = 1'b1;
                end
                else
                begin
                    count_next = count_reg - COUNT_WIDTH'(1);
                end
            end
            STORE_PULSE:
            begin
                // Strobe held low for the store pulse width
                if (count_last)
                begin
                    state_next = STORE_WAIT;
                    count_next = COUNT_WIDTH'(STORE_WAIT_CYCLES);
                end
                else
                begin
                    count_next = count_reg - COUNT_WIDTH'(1);
                    pins_next.store_n = 1'b0;
                end
            end
            STORE_WAIT:
            begin
                // Device busy; no recall or read issued meanwhile
                if (count_last)
                begin
                    state_next = IDLE;
                    ready_next = 1'b1;
                    done_next  = 1'b1;
                end
                else
                begin
                    count_next = count_reg - COUNT_WIDTH'(1);
                end
            end
        endcase
        // Guard against a zero recall length setting
        if (state_reg == RECALL_PULSE && recall_low_len == '0)
        begin
            state_next = IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // All outputs from flip-flops; reset parks both strobes high
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg  <= IDLE;
            count_reg  <= '0;
            mode_reg   <= RECALL_SHORT;
            nv_pins    <= '{store_n: 1'b1, recall_n: 1'b1};
            busy       <= 1'b0;
            read_ready <= 1'b0;
            refused    <= 1'b0;
            done       <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            count_reg  <= count_next;
            mode_reg   <= mode_next;
            nv_pins    <= pins_next;
            busy       <= (state_next != IDLE);
            read_ready <= ready_next;
            refused    <= refused_next;
            done       <= done_next;
        end
    end

endmodule

`default_nettype wire

// ---- nvsram_host_pkg.sv ----
// Purpose: Constants and types for the host controller of a 64 x 4 nonvolatile SRAM
// Assumes: 25 MHz host clock, device pins driven directly from flip-flops
// Notes:   All pulse widths and waits but the one cycle wait after a long recall are derived from their nanosecond figures
package nvsram_host_pkg;

    localparam int CLOCK_PERIOD_NS   = 40;      // Host clock period
    localparam int ADDR_WIDTH        = 6;       // Word address width
    localparam int DATA_WIDTH        = 4;       // Data pin count

    // Times in nanoseconds, as printed
    localparam int RECALL_PULSE_MIN_NS    = 300;
    localparam int RECALL_CYCLE_MIN_NS    = 1400;
    localparam int RECALL_ACCESS_DELAY_NS = 1100;
    localparam int STORE_PULSE_MIN_NS     = 200;
    localparam int STORE_CYCLE_MAX_NS     = 10000000;

    // Least times round up to whole cycles
    localparam int RECALL_PULSE_CYCLES = (RECALL_PULSE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int RECALL_CYCLE_CYCLES = (RECALL_CYCLE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int RECALL_ACCESS_CYCLES = (RECALL_ACCESS_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int STORE_PULSE_CYCLES  = (STORE_PULSE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int STORE_CYCLE_CYCLES  = (STORE_CYCLE_MAX_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    localparam int COUNT_WIDTH = 18;            // Holds the store wait count

    // Recall flavours
    localparam logic RECALL_SHORT = 1'b0;       // Short pulse, then access wait
    localparam logic RECALL_LONG  = 1'b1;       // Full cycle pulse, then a one cycle wait

    // Pins driven toward the device
    typedef struct packed {
        logic store_n;                          // Store strobe, active low
        logic recall_n;                         // Recall strobe, active low
    } nv_pins_type;

    // Host command
    typedef struct packed {
        logic do_store;                         // Request a store
        logic do_recall;                        // Request a recall
        logic recall_mode;                      // RECALL_SHORT or RECALL_LONG
    } command_type;

endpackage

// ---- nvsram_ctl_checker.sv ----
// Purpose: Port assertions for the store and recall sequencer
// Assumes: One clock, synchronous active high reset
// Notes:   Store wait bounds follow the parameter
`timescale 1ns/1ps
`default_nettype none
module nvsram_ctl_checker #(parameter int STORE_WAIT_CYCLES = 20) (
    input wire logic clock, rst, power_good, read_ready, refused, done,
    input wire nvsram_host_pkg::command_type command,
    input wire nvsram_host_pkg::nv_pins_type nv_pins);
    localparam int SW_LO = STORE_WAIT_CYCLES - 1, SW_HI = STORE_WAIT_CYCLES + 3;
    wire logic recall_on = !nv_pins.recall_n;  // Recall strobe asserted
    wire logic store_on = !nv_pins.store_n;    // Store strobe asserted
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_recall_short: assert property ($rose(recall_on) && !$past(command.recall_mode) |->
        recall_on[*8] ##1 !recall_on) else $error("short recall width");
    a_recall_long: assert property ($rose(recall_on) && $past(command.recall_mode) |->
        ##34 recall_on ##1 !recall_on) else $error("long recall width");
    a_access_wait: assert property ($fell(recall_on) && !$past(recall_on, 9) |->
        ##27 !read_ready ##[1:3] done) else $error("recall access wait");
    a_store_pulse: assert property ($rose(store_on) |->
        store_on[*5] ##1 !store_on) else $error("store pulse width");
    a_store_wait: assert property ($fell(store_on) |->
        !done ##[SW_LO:SW_HI] done) else $error("store wait");
    a_power_block: assert property (command.do_store && !command.do_recall && !power_good && read_ready |=>
        refused && !store_on) else $error("store on low supply");
    a_recall_wins: assert property (command.do_store && command.do_recall && read_ready |=>
        recall_on && !store_on) else $error("tie not to recall");
    a_idle_pins: assert property (read_ready |-> !recall_on && !store_on)
        else $error("strobe low while idle");
endmodule
bind nvsram_store_recall_control nvsram_ctl_checker #(.STORE_WAIT_CYCLES(STORE_WAIT_CYCLES)) u_chk (.*);
`default_nettype wire

// ---- nvsram_device_model.sv ----
// Purpose: Behavioural nonvolatile SRAM beyond the sequencer
// Assumes: Strobes seen on the host clock
// Notes:   Copy back into the shadow array is left out
`timescale 1ns/1ps
`default_nettype none
module nvsram_device_model #(parameter int BUSY_CYCLES = 20) (
    input wire logic clock, power_good,
    input wire nvsram_host_pkg::nv_pins_type nv_pins,
    output wire logic storing,
    output wire logic [3:0] data_pins);
    logic [3:0] ram [64], shadow [64];  // Working and nonvolatile arrays
    int         left = 0;               // Store cycles still to run
    assign storing = (left != 0);
    // Float during a transfer, plain RAM otherwise
    assign data_pins = (!nv_pins.recall_n || storing) ? 4'hz : ram[0];
    // Running store ignores strobes; recall wins a tie
    always @(posedge clock)
        if (storing) left <= left - 1;
        else if (!nv_pins.recall_n) ram <= shadow;
        else if (!nv_pins.store_n && power_good) left <= BUSY_CYCLES;
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the store and recall sequencer
// Assumes: Inputs change on the falling clock edge
// Notes:   Store wait shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import nvsram_host_pkg::*;
    logic        clock = 1'b0, rst = 1'b1, power_good = 1'b1, write_active = 1'b0;
    logic        busy, read_ready, refused, done, storing;
    command_type command = '0;
    nv_pins_type nv_pins;
    wire [3:0]   data_pins;
    int          n_mismatch = 0, comparisons = 0;
    // Cycles with reads barred for a short recall
    localparam int RECALL_BUSY = RECALL_PULSE_CYCLES + RECALL_ACCESS_CYCLES;
    always #20 clock = ~clock;
    nvsram_store_recall_control #(.STORE_WAIT_CYCLES(20)) u_nvsram_store_recall_control (.*);
    nvsram_device_model u_nvsram_device_model (.*);
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Stimulus is {command, power_good, write_active}; command lasts one cycle
    task automatic run(input logic [4:0] stim, input int e_rc, e_st, e_rf, e_bz);
        int rc = 0, st = 0, rf = 0, dn = 0, bz = 0, nr = 0;
        {command, power_good, write_active} = stim;
        @(negedge clock);
        command = '0;
        repeat (60)
        begin
            rc += int'(nv_pins.recall_n === 1'b0);
            st += int'(nv_pins.store_n === 1'b0);
            rf += int'(refused === 1'b1);
            dn += int'(done === 1'b1);
            bz += int'(busy === 1'b1);
            nr += int'(read_ready !== 1'b1);
            @(negedge clock);
        end
        comparisons++;
        if (rc != e_rc || st != e_st || rf != e_rf || dn != 1 - e_rf || bz != e_bz || nr != e_bz
            || {read_ready, busy, storing} !== 3'b100)
        begin
            n_mismatch++;
            $display("BAD %0t counts %0d %0d %0d %0d %0d %0d", $time, rc, st, rf, dn, bz, nr);
        end
    endtask
    task automatic t_short_recall; run(5'b01010, 8, 0, 0, RECALL_BUSY); endtask
    task automatic t_long_recall; run(5'b01110, 35, 0, 0, RECALL_CYCLE_CYCLES + 1); endtask
    task automatic t_store; run(5'b10010, 0, 5, 0, STORE_PULSE_CYCLES + 20); endtask
    task automatic t_store_low_power; run(5'b10000, 0, 0, 1, 0); endtask
    task automatic t_store_in_write; run(5'b10011, 0, 0, 1, 0); endtask
    task automatic t_recall_wins; run(5'b11010, 8, 0, 0, RECALL_BUSY); endtask
    // Reset in mid recall parks the strobes and bars reads until released
    task automatic t_reset_mid;
        command = '{do_store: 1'b0, do_recall: 1'b1, recall_mode: RECALL_LONG};
        @(negedge clock);
        command = '0;
        repeat (9) @(negedge clock);
        comparisons++;
        if (nv_pins.recall_n !== 1'b0 || busy !== 1'b1)
        begin
            n_mismatch++;
            $display("BAD %0t recall not running", $time);
        end
        rst = 1'b1;
        repeat (2) @(negedge clock);
        comparisons++;
        if (nv_pins !== 2'b11 || busy !== 1'b0 || read_ready !== 1'b0 || done !== 1'b0)
        begin
            n_mismatch++;
            $display("BAD %0t state during reset", $time);
        end
        rst = 1'b0;
        @(negedge clock);
        comparisons++;
        if (nv_pins !== 2'b11 || busy !== 1'b0 || read_ready !== 1'b1)
        begin
            n_mismatch++;
            $display("BAD %0t state after reset", $time);
        end
    endtask
    initial
    begin
        repeat (5) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        t_short_recall;
        t_long_recall;
        t_store;
        t_store_low_power;
        t_store_in_write;
        t_recall_wins;
        t_reset_mid;
        test_done;
    end
    initial
    begin
        repeat (1000) @(posedge clock);
        n_mismatch++;
        test_done;
    end
endmodule
`default_nettype wire
